/* logic/mcr_pkg.sv */
// constants shared by the metering configuration register slice
// assumes a 200 MHz device clock and the serial host port frame below
package mcr_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [11:0] MCR_ADDR_PULSE_CFG = 12'h425;
  localparam logic [11:0] MCR_ADDR_PART_IDENTIFICATION   = 12'h472;
  localparam logic [11:0] MCR_ADDR_CHAN_SEL  = 12'h42f;

  // ***************************************************************
  // channel source select fields
  // ***************************************************************
  localparam int          MCR_SEL_W       = 3;
  localparam int          MCR_NUM_PATH    = 6;   // ia, ib, ic, in, va, vb
  localparam int          MCR_NUM_SRC     = 7;   // ia, ib, ic, in, va, vb, vc
  localparam int          MCR_SEL_IA_LSB  = 0;
  localparam int          MCR_SEL_IB_LSB  = 3;
  localparam int          MCR_SEL_IC_LSB  = 6;
  localparam int          MCR_SEL_IN_LSB  = 9;
  localparam int          MCR_SEL_VA_LSB  = 12;
  localparam int          MCR_SEL_VB_LSB  = 15;
  localparam logic [2:0]  MCR_SEL_RESET   = 3'h7;
  localparam logic [2:0]  MCR_SEL_OWN     = 3'h7;
  localparam int          MCR_SAMPLE_W    = 24;

  // ***************************************************************
  // pulse width configuration fields
  // ***************************************************************
  localparam int          MCR_NUM_PULSE   = 4;
  localparam int          MCR_LT_LSB      = 19;
  localparam int          MCR_TMR_W       = 19;
  localparam int          MCR_TMR_LSB     = 0;
  localparam logic [18:0] MCR_TMR_RESET   = 19'h0_0000;
  localparam logic [3:0]  MCR_LT_RESET    = 4'h0;

  // ***************************************************************
  // part identification fields
  // ***************************************************************
  localparam int          MCR_FLAG_A_BIT  = 21;
  localparam int          MCR_FLAG_B_BIT  = 20;
  localparam int          MCR_FLAG_C_BIT  = 16;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam longint      MCR_CLK_HZ          = 200_000_000;
  localparam longint      MCR_FIXED_WIDTH_MS  = 80;
  localparam longint      MCR_LOW_FREQ_MHZ    = 6250;   // 6.25 Hz in millihertz
  localparam longint      MCR_FIXED_WIDTH_CYC = MCR_CLK_HZ * MCR_FIXED_WIDTH_MS / 1000;
  localparam longint      MCR_LOW_FREQ_CYC    = MCR_CLK_HZ * 1000 / MCR_LOW_FREQ_MHZ;
  localparam int          MCR_CNT_W           = 32;

  // ***************************************************************
  // serial host port frame
  // ***************************************************************
  localparam int          MCR_CMD_W       = 16;
  localparam int          MCR_DATA_W      = 32;
  localparam int          MCR_ADDR_LSB    = 4;
  localparam int          MCR_READ_BIT    = 3;
  localparam logic [5:0]  MCR_FRAME_BITS  = 6'h30;

  typedef enum logic [1:0] {
    MCR_ST_IDLE,
    MCR_ST_CMD,
    MCR_ST_DATA,
    MCR_ST_DONE
  } mcr_spi_state_e;

endpackage : mcr_pkg

/* logic/mcr_cfg_if.sv */
// configuration carrier from the register file to its consumers
// assumes one clock domain; fields are register outputs
`timescale 1ns/1ps
`default_nettype none
interface mcr_cfg_if;
  logic [mcr_pkg::MCR_NUM_PATH-1:0][mcr_pkg::MCR_SEL_W-1:0] src_sel;   // per data path source code
  logic [mcr_pkg::MCR_NUM_PULSE-1:0]                         long_en;   // per pulse output
  logic [mcr_pkg::MCR_TMR_W-1:0]                             width_tmr; // shared width timer

  modport regs (output src_sel, output long_en, output width_tmr);
  modport user (input src_sel, input long_en, input width_tmr);
endinterface : mcr_cfg_if
`default_nettype wire

/* logic/mcr_src_mux.sv */
// per data path converter source selector
// assumes converter samples and their valid strobe arrive on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module mcr_src_mux (
  input  wire logic                                                   sys_clk_i,
  input  wire logic                                                   sys_rst_i,
  mcr_cfg_if.user                                                     cfg,
  input  wire logic [mcr_pkg::MCR_NUM_SRC-1:0][mcr_pkg::MCR_SAMPLE_W-1:0] adc_sample_i,
  input  wire logic                                                   adc_valid_i,
  output logic      [mcr_pkg::MCR_NUM_PATH-1:0][mcr_pkg::MCR_SAMPLE_W-1:0] path_sample_o,
  output logic                                                        path_valid_o
);

  // ***************************************************************
  // one registered selector per data path
  // ***************************************************************
  genvar p;
  generate
    for (p = 0; p < mcr_pkg::MCR_NUM_PATH; p++) begin : g_path
      // own code picks the path's own converter, other codes any source
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          path_sample_o[p] <= '0;
        end else if (adc_valid_i) begin
          if (cfg.src_sel[p] == mcr_pkg::MCR_SEL_OWN) begin
            path_sample_o[p] <= adc_sample_i[p];
          end else begin
            path_sample_o[p] <= adc_sample_i[cfg.src_sel[p]];
          end
        end
      end
    end
  endgenerate

  // valid follows the sample by the same register stage
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      path_valid_o <= 1'b0;
    end else begin
      path_valid_o <= adc_valid_i;
    end
  end

endmodule : mcr_src_mux
`default_nettype wire

/* logic/mcr_pulse_width.sv */
// active-low pulse stretcher for the four pulse outputs
// assumes one-cycle fire requests from the frequency converters
`timescale 1ns/1ps
`default_nettype none
module mcr_pulse_width #(
  parameter logic [31:0] FIXED_WIDTH_CYC = 32'(mcr_pkg::MCR_FIXED_WIDTH_CYC),
  parameter logic [31:0] LOW_FREQ_CYC    = 32'(mcr_pkg::MCR_LOW_FREQ_CYC)
) (
  input  wire logic                              sys_clk_i,
  input  wire logic                              sys_rst_i,
  mcr_cfg_if.user                                cfg,
  input  wire logic [mcr_pkg::MCR_NUM_PULSE-1:0] fire_i,
  output logic      [mcr_pkg::MCR_NUM_PULSE-1:0] pulse_n_o
);

  genvar k;
  generate
    for (k = 0; k < mcr_pkg::MCR_NUM_PULSE; k++) begin : g_pulse
      logic [31:0] period_reg;   // cycles since last fire, saturating
      logic [31:0] width_reg;    // cycles of low level still to drive
      logic [31:0] width_next;

      // width for a new pulse: timer, fixed, or half the last period
      always_comb begin
        if (cfg.long_en[k]) begin
          width_next = (cfg.width_tmr == '0) ? 32'h0000_0001 : 32'(cfg.width_tmr);
        end else if (period_reg >= LOW_FREQ_CYC) begin
          width_next = FIXED_WIDTH_CYC;
        end else begin
          width_next = (period_reg[31:1] == '0) ? 32'h0000_0001 : {1'b0, period_reg[31:1]};
        end
      end

      // interval measurement between fire requests
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          period_reg <= 32'hffff_ffff;
        end else if (fire_i[k]) begin
          period_reg <= 32'h0000_0001;
        end else if (period_reg != 32'hffff_ffff) begin
          period_reg <= period_reg + 32'h0000_0001;
        end
      end

      // low level held for the chosen width; a fire while low restarts it
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          width_reg    <= '0;
          pulse_n_o[k] <= 1'b1;
        end else if (fire_i[k]) begin
          width_reg    <= width_next - 32'h0000_0001;
          pulse_n_o[k] <= 1'b0;
        end else if (width_reg != '0) begin
          width_reg    <= width_reg - 32'h0000_0001;
          pulse_n_o[k] <= 1'b0;
        end else begin
          pulse_n_o[k] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule : mcr_pulse_width
`default_nettype wire

/* logic/mcr_regs.sv */
// configuration register slice: source selectors, pulse widths, part_identification
// assumes the host port pins are synchronous to sys_clk_i (sclk well below clk/4)
`timescale 1ns/1ps
`default_nettype none

// How it works
// - phase A voltage selector at bits 14:12, reset 7, 7 picks own converter
// - neutral current selector at bits 11:9, reset 7, 7 picks own converter
// - phase C current selector at bits 8:6, reset 7, 7 picks own converter
// - phase B current selector at bits 5:3, reset 7, 7 picks own converter
// - phase A current selector at bits 2:0, reset 7, 7 picks own converter
// - selector codes 0 to 6 pick any source converter, same map for all
// - bit 22 set: fourth pulse output width comes from the shared timer
// - bit 21 set: third pulse output width comes from the shared timer
// - bit 20 set: second pulse output width comes from the shared timer
// - bit 19 set: first pulse output width comes from the shared timer
// - enable clear: fixed 80 ms low pulse when frequency is below 6.25 Hz
// - 19-bit read/write width timer at bits 18:0, resets to zero
// - read-only part flags at bits 21, 20, 16; other bits read zero
// - phase B voltage selector at bits 17:15, 7 picks own converter
module mcr_regs #(
  parameter logic [31:0] FIXED_WIDTH_CYC = 32'(mcr_pkg::MCR_FIXED_WIDTH_CYC),
  parameter logic [31:0] LOW_FREQ_CYC    = 32'(mcr_pkg::MCR_LOW_FREQ_CYC),
  parameter logic        PRODUCT_FLAG_A  = 1'b0,  // arbitrary value, none of the flagged products
  parameter logic        PRODUCT_FLAG_B  = 1'b0,  // arbitrary value, none of the flagged products
  parameter logic        PRODUCT_FLAG_C  = 1'b0   // arbitrary value, none of the flagged products
) (
  input  wire logic                                                       sys_clk_i,
  input  wire logic                                                       sys_rst_i,
  input  wire logic                                                       spi_sclk_i,
  input  wire logic                                                       spi_cs_n_i,
  input  wire logic                                                       spi_mosi_i,
  output logic                                                            spi_miso_o,
  output logic                                                            spi_miso_oe_o,
  input  wire logic [mcr_pkg::MCR_NUM_SRC-1:0][mcr_pkg::MCR_SAMPLE_W-1:0] adc_sample_i,
  input  wire logic                                                       adc_valid_i,
  output logic      [mcr_pkg::MCR_NUM_PATH-1:0][mcr_pkg::MCR_SAMPLE_W-1:0] path_sample_o,
  output logic                                                            path_valid_o,
  input  wire logic [mcr_pkg::MCR_NUM_PULSE-1:0]                          pulse_fire_i,
  output logic      [mcr_pkg::MCR_NUM_PULSE-1:0]                          pulse_output_n_o
);

  // ***************************************************************
  // register storage
  // ***************************************************************
  // channel source selectors
  logic [2:0]  phase_a_current_source_select_reg;
  logic [2:0]  phase_b_current_source_select_reg;
  logic [2:0]  phase_c_current_source_select_reg;
  logic [2:0]  neutral_current_source_select_reg;
  logic [2:0]  phase_a_voltage_source_select_reg;
  logic [2:0]  phase_b_voltage_source_select_reg;

  // pulse width configuration
  logic [3:0]  pulse_long_width_enable_reg;   // bit 0 is pulse1 .. bit 3 is pulse4
  logic [18:0] pulse_width_timer_reg;

  // ***************************************************************
  // host port framing
  // ***************************************************************
  // 16 command bits, then 32 data bits, msb first
  // command: 15:4 address, 3 read, 2:0 unused
  // host clock phases under one clock are lost

  // frame control
  mcr_pkg::mcr_spi_state_e state_reg;
  logic        sclk_prev_reg;
  logic [5:0]  bit_cnt_reg;
  logic [15:0] cmd_reg;

  // data words
  logic [31:0] shift_in_reg;
  logic [31:0] shift_out_reg;

  // write request
  logic        wr_commit_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] wr_data_reg;

  // host pin decode
  logic        sclk_rise;
  logic        sclk_fall;
  logic [11:0] cmd_addr;
  logic        cmd_read;
  logic [31:0] rd_data;
  logic [15:0] cmd_next;

  // host clock edges
  assign sclk_rise = spi_sclk_i & ~sclk_prev_reg;
  assign sclk_fall = ~spi_sclk_i & sclk_prev_reg;

  // command with the bit on the pin
  assign cmd_next  = {cmd_reg[14:0], spi_mosi_i};
  assign cmd_addr  = cmd_next[mcr_pkg::MCR_ADDR_LSB +: 12];
  assign cmd_read  = cmd_next[mcr_pkg::MCR_READ_BIT];

  // resets to the idle level: no false rise
  // clock pin history for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= spi_sclk_i;
    end
  end

  // decoded as the last command bit arrives
  // read mux; unmapped and reserved bits give zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (cmd_addr)
      mcr_pkg::MCR_ADDR_CHAN_SEL: begin
        // bits 31:18 stay zero
        rd_data[mcr_pkg::MCR_SEL_IA_LSB +: 3] = phase_a_current_source_select_reg;
        rd_data[mcr_pkg::MCR_SEL_IB_LSB +: 3] = phase_b_current_source_select_reg;
        rd_data[mcr_pkg::MCR_SEL_IC_LSB +: 3] = phase_c_current_source_select_reg;
        rd_data[mcr_pkg::MCR_SEL_IN_LSB +: 3] = neutral_current_source_select_reg;
        rd_data[mcr_pkg::MCR_SEL_VA_LSB +: 3] = phase_a_voltage_source_select_reg;
        rd_data[mcr_pkg::MCR_SEL_VB_LSB +: 3] = phase_b_voltage_source_select_reg;
      end

      mcr_pkg::MCR_ADDR_PULSE_CFG: begin
        // bits 31:23 stay zero
        rd_data[mcr_pkg::MCR_LT_LSB +: 4]  = pulse_long_width_enable_reg;
        rd_data[mcr_pkg::MCR_TMR_LSB +: 19] = pulse_width_timer_reg;
      end

      mcr_pkg::MCR_ADDR_PART_IDENTIFICATION: begin
        rd_data[mcr_pkg::MCR_FLAG_A_BIT] = PRODUCT_FLAG_A;
        rd_data[mcr_pkg::MCR_FLAG_B_BIT] = PRODUCT_FLAG_B;
        rd_data[mcr_pkg::MCR_FLAG_C_BIT] = PRODUCT_FLAG_C;
      end

      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // frame state: 16 command bits then 32 data bits, msb first
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg   <= mcr_pkg::MCR_ST_IDLE;
      bit_cnt_reg <= 6'h00;
      cmd_reg     <= 16'h0000;
    end else if (spi_cs_n_i) begin
      state_reg   <= mcr_pkg::MCR_ST_IDLE;
      bit_cnt_reg <= 6'h00;
    end else begin
      case (state_reg)
        mcr_pkg::MCR_ST_IDLE: begin
          state_reg <= mcr_pkg::MCR_ST_CMD;
        end

        mcr_pkg::MCR_ST_CMD: begin
          if (sclk_rise) begin
            cmd_reg     <= cmd_next;
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'(mcr_pkg::MCR_CMD_W - 1)) begin
              state_reg <= mcr_pkg::MCR_ST_DATA;
            end
          end
        end

        mcr_pkg::MCR_ST_DATA: begin
          if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == mcr_pkg::MCR_FRAME_BITS - 6'h01) begin
              state_reg <= mcr_pkg::MCR_ST_DONE;
            end
          end
        end

        mcr_pkg::MCR_ST_DONE: begin
          state_reg <= mcr_pkg::MCR_ST_DONE;  // extra clocks ignored until cs rises
        end

        default: begin
          state_reg <= mcr_pkg::MCR_ST_IDLE;
        end
      endcase
    end
  end

  // incoming data word and write commit after the last data bit
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      shift_in_reg  <= 32'h0000_0000;
      wr_commit_reg <= 1'b0;
      wr_addr_reg   <= 12'h000;
      wr_data_reg   <= 32'h0000_0000;
    end else begin
      wr_commit_reg <= 1'b0;
      if (!spi_cs_n_i && state_reg == mcr_pkg::MCR_ST_DATA && sclk_rise) begin
        shift_in_reg <= {shift_in_reg[30:0], spi_mosi_i};
        if (bit_cnt_reg == mcr_pkg::MCR_FRAME_BITS - 6'h01 && !cmd_reg[mcr_pkg::MCR_READ_BIT]) begin
          wr_commit_reg <= 1'b1;
          wr_addr_reg   <= cmd_reg[mcr_pkg::MCR_ADDR_LSB +: 12];
          wr_data_reg   <= {shift_in_reg[30:0], spi_mosi_i};
        end
      end
    end
  end

  // enable follows the read bit
  // read word loaded with the last command bit, shifted on falling edges
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      shift_out_reg <= 32'h0000_0000;
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (spi_cs_n_i) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (state_reg == mcr_pkg::MCR_ST_CMD && sclk_rise &&
                 bit_cnt_reg == 6'(mcr_pkg::MCR_CMD_W - 1)) begin
      shift_out_reg <= rd_data;
      spi_miso_oe_o <= cmd_read;
    end else if (state_reg == mcr_pkg::MCR_ST_DATA && sclk_fall) begin
      spi_miso_o    <= shift_out_reg[31];
      shift_out_reg <= {shift_out_reg[30:0], 1'b0};
    end else if (state_reg == mcr_pkg::MCR_ST_DONE) begin
      spi_miso_oe_o <= 1'b0;
    end
  end

  // ***************************************************************
  // register writes
  // ***************************************************************

  // a write lands one clock after its last bit

  // channel source selectors; bits above 17 are dropped
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      phase_a_current_source_select_reg <= mcr_pkg::MCR_SEL_RESET;
      phase_b_current_source_select_reg <= mcr_pkg::MCR_SEL_RESET;
      phase_c_current_source_select_reg <= mcr_pkg::MCR_SEL_RESET;
      neutral_current_source_select_reg <= mcr_pkg::MCR_SEL_RESET;
      phase_a_voltage_source_select_reg <= mcr_pkg::MCR_SEL_RESET;
      phase_b_voltage_source_select_reg <= mcr_pkg::MCR_SEL_RESET;
    end else if (wr_commit_reg && wr_addr_reg == mcr_pkg::MCR_ADDR_CHAN_SEL) begin
      phase_a_current_source_select_reg <= wr_data_reg[mcr_pkg::MCR_SEL_IA_LSB +: 3];
      phase_b_current_source_select_reg <= wr_data_reg[mcr_pkg::MCR_SEL_IB_LSB +: 3];
      phase_c_current_source_select_reg <= wr_data_reg[mcr_pkg::MCR_SEL_IC_LSB +: 3];
      neutral_current_source_select_reg <= wr_data_reg[mcr_pkg::MCR_SEL_IN_LSB +: 3];
      phase_a_voltage_source_select_reg <= wr_data_reg[mcr_pkg::MCR_SEL_VA_LSB +: 3];
      phase_b_voltage_source_select_reg <= wr_data_reg[mcr_pkg::MCR_SEL_VB_LSB +: 3];
    end
  end

  // enables and timer written together
  // pulse width configuration; bits 31:23 are dropped
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pulse_long_width_enable_reg <= mcr_pkg::MCR_LT_RESET;
      pulse_width_timer_reg       <= mcr_pkg::MCR_TMR_RESET;
    end else if (wr_commit_reg && wr_addr_reg == mcr_pkg::MCR_ADDR_PULSE_CFG) begin
      pulse_long_width_enable_reg <= wr_data_reg[mcr_pkg::MCR_LT_LSB +: 4];
      pulse_width_timer_reg       <= wr_data_reg[mcr_pkg::MCR_TMR_LSB +: 19];
    end
  end

  // ***************************************************************
  // consumers of the configuration
  // ***************************************************************
  // one carrier to both consumers
  mcr_cfg_if cfg_bus ();

  // path order matches source order: ia, ib, ic, in, va, vb
  assign cfg_bus.src_sel[0] = phase_a_current_source_select_reg;
  assign cfg_bus.src_sel[1] = phase_b_current_source_select_reg;
  assign cfg_bus.src_sel[2] = phase_c_current_source_select_reg;
  assign cfg_bus.src_sel[3] = neutral_current_source_select_reg;
  assign cfg_bus.src_sel[4] = phase_a_voltage_source_select_reg;
  assign cfg_bus.src_sel[5] = phase_b_voltage_source_select_reg;
  assign cfg_bus.long_en    = pulse_long_width_enable_reg;
  assign cfg_bus.width_tmr  = pulse_width_timer_reg;

  // samples onto the data paths
  mcr_src_mux u_src_mux (
    .sys_clk_i     (sys_clk_i),
    .sys_rst_i     (sys_rst_i),
    .cfg           (cfg_bus),
    .adc_sample_i  (adc_sample_i),
    .adc_valid_i   (adc_valid_i),
    .path_sample_o (path_sample_o),
    .path_valid_o  (path_valid_o)
  );

  // pulse output stretchers
  mcr_pulse_width #(
    .FIXED_WIDTH_CYC (FIXED_WIDTH_CYC),
    .LOW_FREQ_CYC    (LOW_FREQ_CYC)
  ) u_pulse_width (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .cfg       (cfg_bus),
    .fire_i    (pulse_fire_i),
    .pulse_n_o (pulse_output_n_o)
  );

endmodule : mcr_regs
`default_nettype wire

/* test/mcr_regs_properties.sv */
// port checker for the configuration register slice
// assumes a bind onto mcr_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_properties (
  input wire logic                                                       sys_clk_i,
  input wire logic                                                       sys_rst_i,
  input wire logic                                                       spi_sclk_i,
  input wire logic                                                       spi_cs_n_i,
  input wire logic                                                       spi_mosi_i,
  input wire logic                                                       spi_miso_o,
  input wire logic                                                       spi_miso_oe_o,
  input wire logic [mcr_pkg::MCR_NUM_SRC-1:0][mcr_pkg::MCR_SAMPLE_W-1:0]  adc_sample_i,
  input wire logic                                                       adc_valid_i,
  input wire logic [mcr_pkg::MCR_NUM_PATH-1:0][mcr_pkg::MCR_SAMPLE_W-1:0] path_sample_o,
  input wire logic                                                       path_valid_o,
  input wire logic [mcr_pkg::MCR_NUM_PULSE-1:0]                          pulse_fire_i,
  input wire logic [mcr_pkg::MCR_NUM_PULSE-1:0]                          pulse_output_n_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ********
  // properties
  // ********
  // frame select held off for two edges
  sequence s_cs_idle;
    spi_cs_n_i ##1 spi_cs_n_i;
  endsequence
  property p_oe_off;
    s_cs_idle |-> !spi_miso_oe_o;
  endproperty
  property p_valid_follow;
    adc_valid_i |=> path_valid_o;
  endproperty
  property p_valid_cause;
    path_valid_o |-> $past(adc_valid_i);
  endproperty
  property p_path_hold;
    !adc_valid_i |=> $stable(path_sample_o);
  endproperty
  // a fire request drives the output low on the next edge
  property p_fire(k);
    pulse_fire_i[k] |=> !pulse_output_n_o[k];
  endproperty
  property p_no_spurious;
    pulse_output_n_o[1] && !pulse_fire_i[1] |=> pulse_output_n_o[1];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso enable high outside a frame");
  a_valid_follow: assert property (p_valid_follow) else $error("path valid missing");
  a_valid_cause: assert property (p_valid_cause) else $error("path valid without strobe");
  a_path_hold: assert property (p_path_hold) else $error("path sample moved without strobe");
  a_fire1: assert property (p_fire(0)) else $error("output 1 not low after fire");
  a_fire2: assert property (p_fire(1)) else $error("output 2 not low after fire");
  a_fire3: assert property (p_fire(2)) else $error("output 3 not low after fire");
  a_fire4: assert property (p_fire(3)) else $error("output 4 not low after fire");
  a_no_spurious: assert property (p_no_spurious) else $error("output 2 fell without fire");
endmodule : mcr_regs_properties
`default_nettype wire

/* test/mcr_regs_test.sv */
// self-checking bench for the configuration register slice
// assumes the host port frame and timing given by the designer
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_test;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic spi_sclk_i = 1'b1;
  logic spi_cs_n_i = 1'b1;
  logic spi_mosi_i = 1'b0;
  logic adc_valid_i = 1'b0;
  logic spi_miso_o;
  logic spi_miso_oe_o;
  logic path_valid_o;
  logic [3:0] pulse_fire_i = 4'h0;
  logic [3:0] pulse_output_n_o;
  logic [6:0][23:0] adc_sample_i = '0;
  logic [5:0][23:0] path_sample_o;
  logic [31:0] q, w, t;
  logic [17:0] sel;
  int mismatches = 0;
  int tests_run = 0;
  int seed;
  mcr_regs #(.FIXED_WIDTH_CYC(32'h0000_0028), .LOW_FREQ_CYC(32'h0000_0050)) DUT (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
    .adc_sample_i(adc_sample_i), .adc_valid_i(adc_valid_i), .path_sample_o(path_sample_o),
    .path_valid_o(path_valid_o), .pulse_fire_i(pulse_fire_i), .pulse_output_n_o(pulse_output_n_o));
  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ********
  // tasks
  // ********
  task automatic finish_test();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one 48-bit frame, shift on fall, sample on rise
  task automatic spi(input logic [11:0] a, input logic r, input logic [31:0] d, output logic [31:0] o);
    logic [47:0] f;
    f = {a, r, 3'h0, d};
    o = '0;
    spi_cs_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    for (int i = 47; i >= 0; i--) begin
      spi_sclk_i = 1'b0;
      spi_mosi_i = f[i];
      repeat (3) @(negedge sys_clk_i);
      if (i < 32) o[i] = spi_miso_o;
      spi_sclk_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
    end
    spi_cs_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
  endtask : spi
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] o;
    spi(a, 1'b1, 32'h0000_0000, o);
    check(o, exp);
  endtask : rd
  // fire one output and count its low cycles
  task automatic pulse(input int k, output logic [31:0] n);
    n = '0;
    pulse_fire_i[k] = 1'b1;
    @(negedge sys_clk_i);
    pulse_fire_i[k] = 1'b0;
    while (pulse_output_n_o[k] !== 1'b1 && n < 3000) begin
      n++;
      @(negedge sys_clk_i);
    end
    if (n == 3000) begin
      mismatches++;
      finish_test();
    end
    repeat (2) @(negedge sys_clk_i);
  endtask : pulse
  function automatic logic [31:0] exp_src(input logic [17:0] s, input int p);
    logic [2:0] c;
    c = s[3*p+:3];
    return 32'((c == 3'h7) ? adc_sample_i[p] : adc_sample_i[c]);
  endfunction : exp_src
  // ********
  // main sequence
  // ********
  initial begin
    seed = 32'h5f24_8199;
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
    rd(mcr_pkg::MCR_ADDR_CHAN_SEL, 32'h0003_ffff);
    rd(mcr_pkg::MCR_ADDR_PULSE_CFG, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      pulse(k, w);
      check(w, 32'h0000_0028);
      pulse(k, w);
      check(w, 32'h0000_0015);
    end
    for (int i = 0; i < 16; i++) begin
      sel = (i < 8) ? {6{3'(i)}} : 18'($random(seed));
      spi(mcr_pkg::MCR_ADDR_CHAN_SEL, 1'b0, {14'($random(seed)), sel}, q);
      rd(mcr_pkg::MCR_ADDR_CHAN_SEL, {14'h0, sel});
      for (int s = 0; s < 7; s++) adc_sample_i[s] = 24'($random(seed));
      adc_valid_i = 1'b1;
      @(negedge sys_clk_i);
      adc_valid_i = 1'b0;
      check(32'(path_valid_o), 32'h0000_0001);
      for (int p = 0; p < 6; p++) check(32'(path_sample_o[p]), exp_src(sel, p));
    end
    spi(mcr_pkg::MCR_ADDR_PULSE_CFG, 1'b0, 32'hffff_ffff, q);
    rd(mcr_pkg::MCR_ADDR_PULSE_CFG, 32'h007f_ffff);
    spi(mcr_pkg::MCR_ADDR_PART_IDENTIFICATION, 1'b0, 32'hffff_ffff, q);
    rd(mcr_pkg::MCR_ADDR_PART_IDENTIFICATION, 32'h0000_0000);
    spi(12'h000, 1'b0, 32'hffff_ffff, q);
    rd(12'h000, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      t = (32'($random(seed)) & 32'h0000_007f) + 32'h0000_0001;
      spi(mcr_pkg::MCR_ADDR_PULSE_CFG, 1'b0, (32'h0000_0001 << (19 + k)) | t, q);
      pulse(k, w);
      check(w, t);
    end
    finish_test();
  end
endmodule : mcr_regs_test
bind mcr_regs mcr_regs_properties u_props (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .adc_sample_i(adc_sample_i), .adc_valid_i(adc_valid_i), .path_sample_o(path_sample_o),
  .path_valid_o(path_valid_o), .pulse_fire_i(pulse_fire_i), .pulse_output_n_o(pulse_output_n_o));
`default_nettype wire
